// ### src/dis_pkg.sv
// constants and types for the diagnostic interrupt section builder
package dis_pkg;
	localparam int          SECT_BYTES    = 20;
	localparam logic [5:0]  SECT_LEN      = 6'h14;
	localparam logic [1:0]  HDR_MOD_CODE  = 2'h0;
	localparam logic        ALARM_MARK    = 1'h1;
	localparam logic [6:0]  TYPE_DIAG     = 7'h01;
	localparam logic [6:0]  TYPE_PROC     = 7'h02;
	localparam logic [1:0]  KIND_PROC     = 2'h0;
	localparam logic [1:0]  KIND_DIAG_IN  = 2'h1;
	localparam logic [1:0]  KIND_DIAG_OUT = 2'h2;
	localparam logic [1:0]  KIND_RSVD     = 2'h3;
	localparam logic [7:0]  SLOT_MIN      = 8'h01;
	localparam logic [7:0]  SLOT_MAX      = 8'h20;
	localparam logic [5:0]  SEQ_MIN       = 6'h01;
	localparam logic [5:0]  SEQ_MAX       = 6'h20;
	localparam logic [3:0]  CLASS_DIGITAL = 4'hf;
	localparam logic [3:0]  CLASS_ANALOG  = 4'h5;
	localparam logic [3:0]  function_module_class = 4'h8;
	localparam logic [3:0]  comm_processor_class  = 4'hc;
	localparam logic [7:0]  MTYPE_DI      = 8'h70;
	localparam logic [7:0]  MTYPE_AI      = 8'h71;
	localparam logic [7:0]  MTYPE_DO      = 8'h72;
	localparam logic [7:0]  MTYPE_AO      = 8'h73;
	localparam logic [7:0]  MTYPE_AIO     = 8'h74;
	localparam logic [7:0]  MTYPE_CNT     = 8'h76;
	localparam int          IDX_HDR       = 0;
	localparam int          IDX_TYPE      = 1;
	localparam int          IDX_SLOT      = 2;
	localparam int          IDX_STATE     = 3;
	localparam int          IDX_REC0      = 4;
	localparam int          IDX_MODTYPE   = 8;
	localparam int          IDX_CHLEN     = 9;
	localparam int          IDX_CHCNT     = 10;
	localparam int          IDX_CHEVT     = 12;
	localparam int          CH_GROUPS     = 8;
	localparam logic [7:0]  X5_MASK       = 8'h3f;
	localparam logic [7:0]  X6_MASK       = 8'h7f;
	localparam logic [7:0]  X7_MASK       = 8'h40;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_SECT0    = 8'h08;
	localparam int          SECT_WORDS    = 5;
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_RELEASE  = 1;
	localparam int          CTRL_CLR_REF  = 2;
	localparam logic        CTRL_EN_RST   = 1'h1;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef logic [SECT_BYTES-1:0][7:0] dis_sect_t;
	typedef enum {RG_CTRL, RG_STATUS, RG_SECT, RG_NONE} dis_region_t;
endpackage

// ### src/dis_builder.sv
// interrupt section builder with an AXI4-Lite register slave
// Function
// - header bits 5:0 hold section length twenty
// - header bits 7:6 carry module-related code
// - byte two: interrupt type plus marker bit
// - byte three carries slot 1 to 32
// - state bits: process, arriving, departing; never 11
// - bit 2 zero, sequence number in 7:3
// - diagnostic byte five: eight module fault bits
// - module class in low nibble of byte six
// - channel/user info bits 4,5; 7:6 zero
// - byte seven status flags, bit 7 zero
// - byte eight only process-interrupt-lost bit
// - byte nine gives module type code
// - channel diag length and channel count bytes
// - one event byte per channel group 0-7
// - diagnostic fills record 0 and record 1
// - process alarm fills four info bytes
// - one interrupt per frame, section last
// - section never exceeds twenty bytes
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dis_builder #(
	parameter int ADDR_W = 8
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  nrst_in,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  alarm_req_in,
	input  wire logic [1:0]            alarm_kind_in,
	input  wire logic [7:0]            alarm_slot_in,
	input  wire logic [31:0]           alarm_rec0_in,
	input  wire logic [7:0]            alarm_modtype_in,
	input  wire logic [7:0]            alarm_chlen_in,
	input  wire logic [7:0]            alarm_chcnt_in,
	input  wire logic [63:0]           alarm_chevt_in,
	output logic                       alarm_ready_out,
	output logic                       sect_valid_out,
	output logic [5:0]                 sect_len_out,
	input  wire logic [4:0]            sect_rd_idx_in,
	output logic [7:0]                 sect_rd_byte_out,
	input  wire logic                  sect_done_in
);
	import dis_pkg::*;

	function automatic dis_region_t region(input logic [ADDR_W-1:0] a);
		logic [7:0] w;
		w = a[7:0];
		if (w == ADDR_CTRL)
			return RG_CTRL;
		else if (w == ADDR_STATUS)
			return RG_STATUS;
		else if (w >= ADDR_SECT0 && w < ADDR_SECT0 + 8'(4 * SECT_WORDS)
			&& w[1:0] == 2'h0)
			return RG_SECT;
		else
			return RG_NONE;
	endfunction

	dis_sect_t   sect_reg;
	dis_sect_t   sect_next;
	logic        pend_reg;
	logic        pend_next;
	logic        en_reg;
	logic        refused_reg;
	logic [5:0]  seq_reg;
	logic [5:0]  last_seq_reg;
	logic        accept;
	logic        fields_ok;
	logic        aw_got_reg;
	logic        w_got_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_do;
	logic        ctrl_wr;
	logic        release_pulse;
	logic        clr_ref_pulse;
	logic [2:0]  sect_word;

	// reserved kind and out-of-range slots never reach the frame
	assign fields_ok = (alarm_kind_in != KIND_RSVD)
		&& alarm_slot_in >= SLOT_MIN && alarm_slot_in <= SLOT_MAX;
	// ready is registered from the next pending state, so no second
	// alarm can slip in during the cycle the section fills
	assign accept = alarm_req_in && alarm_ready_out && fields_ok;

	always_comb begin
		sect_next = '0;
		sect_next[IDX_HDR] = {HDR_MOD_CODE, SECT_LEN};
		sect_next[IDX_TYPE] = {ALARM_MARK,
			(alarm_kind_in == KIND_PROC) ? TYPE_PROC : TYPE_DIAG};
		sect_next[IDX_SLOT] = alarm_slot_in;
		// the field is five bits wide: sequence 32 shows as 00000
		sect_next[IDX_STATE] = {seq_reg[4:0], 1'b0, alarm_kind_in};
		if (alarm_kind_in == KIND_PROC) begin
			for (int b = 0; b < 4; b++) begin
				sect_next[IDX_REC0 + b] = alarm_rec0_in[b*8 +: 8];
			end
		end else begin
			sect_next[IDX_REC0] = alarm_rec0_in[7:0];
			sect_next[IDX_REC0+1] = alarm_rec0_in[15:8] & X5_MASK;
			sect_next[IDX_REC0+2] = alarm_rec0_in[23:16] & X6_MASK;
			sect_next[IDX_REC0+3] = alarm_rec0_in[31:24] & X7_MASK;
			sect_next[IDX_MODTYPE] = alarm_modtype_in;
			sect_next[IDX_CHLEN] = alarm_chlen_in;
			sect_next[IDX_CHCNT] = alarm_chcnt_in;
			for (int g = 0; g < CH_GROUPS; g++) begin
				if (8'(g) < alarm_chcnt_in)
					sect_next[IDX_CHEVT + g] = alarm_chevt_in[g*8 +: 8];
			end
		end
	end

	always_comb begin
		pend_next = pend_reg;
		if (sect_done_in || release_pulse)
			pend_next = 1'b0;
		if (accept)
			pend_next = 1'b1;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sect_reg <= '0;
		end else if (accept) begin
			sect_reg <= sect_next;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pend_reg        <= 1'b0;
			alarm_ready_out <= 1'b0;
			sect_valid_out  <= 1'b0;
			sect_len_out    <= '0;
		end else begin
			pend_reg        <= pend_next;
			alarm_ready_out <= en_reg && !pend_next;
			sect_valid_out  <= pend_next;
			sect_len_out    <= pend_next ? SECT_LEN : 6'h00;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			seq_reg      <= SEQ_MIN;
			last_seq_reg <= '0;
		end else if (accept) begin
			last_seq_reg <= seq_reg;
			seq_reg <= (seq_reg == SEQ_MAX) ? SEQ_MIN : seq_reg + 6'h01;
		end
	end

	// the frame assembler fetches bytes after its other sections
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sect_rd_byte_out <= '0;
		end else if (pend_reg && 32'(sect_rd_idx_in) < SECT_BYTES) begin
			sect_rd_byte_out <= sect_reg[sect_rd_idx_in];
		end else begin
			sect_rd_byte_out <= '0;
		end
	end

	// a refusal in the cycle of the clear still leaves the flag set
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			refused_reg <= 1'b0;
		end else if (alarm_req_in && !accept) begin
			refused_reg <= 1'b1;
		end else if (clr_ref_pulse) begin
			refused_reg <= 1'b0;
		end
	end

	assign wr_do   = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign ctrl_wr = wr_do && region(aw_addr_reg) == RG_CTRL
		&& w_strb_reg[0];
	assign release_pulse = ctrl_wr && w_data_reg[CTRL_RELEASE];
	assign clr_ref_pulse = ctrl_wr && w_data_reg[CTRL_CLR_REF];

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			en_reg <= CTRL_EN_RST;
		end else if (ctrl_wr) begin
			en_reg <= w_data_reg[CTRL_EN];
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_awready <= 1'b0;
			aw_got_reg    <= 1'b0;
			aw_addr_reg   <= '0;
		end else begin
			s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got_reg
				&& !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_wready <= 1'b0;
			w_got_reg    <= 1'b0;
			w_data_reg   <= '0;
			w_strb_reg   <= '0;
		end else begin
			s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got_reg
				&& !s_axi_bvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_do) begin
				w_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (region(aw_addr_reg) == RG_NONE) ?
				RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign sect_word = 3'((s_axi_araddr[7:0] - ADDR_SECT0) >> 2);

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid
				&& !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (region(s_axi_araddr))
					RG_CTRL: s_axi_rdata <= {31'h0, en_reg};
					RG_STATUS: s_axi_rdata <= {15'h0, alarm_ready_out,
						2'h0, last_seq_reg, 6'h0, refused_reg, pend_reg};
					RG_SECT: s_axi_rdata <= {sect_reg[4*sect_word+3],
						sect_reg[4*sect_word+2], sect_reg[4*sect_word+1],
						sect_reg[4*sect_word]};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	sequence s_take;
		accept;
	endsequence
	sequence s_held;
		sect_valid_out ##0 sect_len_out == SECT_LEN;
	endsequence

	hdr_byte_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg |-> sect_reg[IDX_HDR] == {HDR_MOD_CODE, SECT_LEN})
		else $error("header byte wrong");
	type_byte_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		s_take |=> sect_reg[IDX_TYPE] == {ALARM_MARK,
			($past(alarm_kind_in) == KIND_PROC) ? TYPE_PROC : TYPE_DIAG})
		else $error("type byte wrong");
	slot_byte_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		s_take |=> sect_reg[IDX_SLOT] == $past(alarm_slot_in))
		else $error("slot byte wrong");
	state_bits_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg |-> sect_reg[IDX_STATE][2:0] != 3'h3
			&& !sect_reg[IDX_STATE][2])
		else $error("state bits reserved");
	seq_wrap_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		s_take |=> seq_reg == (($past(seq_reg) == SEQ_MAX) ? SEQ_MIN
			: $past(seq_reg) + 6'h01))
		else $error("sequence did not advance");
	one_alarm_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		s_take |=> s_held ##0 !alarm_ready_out)
		else $error("section not held after accept");
	rsvd_bits_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg && sect_reg[IDX_TYPE][1:0] == TYPE_DIAG[1:0] |->
			(sect_reg[IDX_REC0+1] & ~X5_MASK) == 8'h00
			&& (sect_reg[IDX_REC0+2] & ~X6_MASK) == 8'h00
			&& (sect_reg[IDX_REC0+3] & ~X7_MASK) == 8'h00)
		else $error("reserved bits set");
	chan_zero_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		s_take ##0 alarm_chcnt_in == 8'h00 |=>
			sect_reg[IDX_CHEVT] == 8'h00 && sect_reg[SECT_BYTES-1] == 8'h00)
		else $error("unused channel byte set");
	release_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg && sect_done_in && !accept |=> !sect_valid_out
			&& sect_len_out == 6'h00 && alarm_ready_out == $past(en_reg))
		else $error("section not released");
	// a process alarm carries only four info bytes, the rest stay clear
	proc_zero_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg && sect_reg[IDX_TYPE][1:0] == TYPE_PROC[1:0] |->
			sect_reg[SECT_BYTES-1:IDX_MODTYPE] == '0)
		else $error("process section tail set");
	seq_field_a: assert property (@(posedge sys_clk_in)
		disable iff (!nrst_in)
		pend_reg |-> sect_reg[IDX_STATE][7:3] == last_seq_reg[4:0])
		else $error("sequence field wrong");
endmodule

// ### bench/dis_master_model.sv
// fieldbus master model that fetches one interrupt section per frame
`timescale 1ns/1ps
module dis_master_model (
	input  wire logic       sys_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       start_in,
	input  wire logic       slow_in,
	input  wire logic       sect_valid_in,
	input  wire logic [7:0] sect_byte_in,
	output logic [4:0]      rd_idx_out,
	output logic            done_out,
	output logic            busy_out,
	output dis_pkg::dis_sect_t frame_out
);
	import dis_pkg::*;
	initial begin
		rd_idx_out = 5'h00;
		done_out = 1'b0;
		busy_out = 1'b0;
		frame_out = '0;
		forever begin
			@(posedge sys_clk_in);
			// one section per frame, fetched last, then released
			if (start_in && sect_valid_in && nrst_in) begin
				busy_out <= 1'b1;
				for (int k = 0; k < SECT_BYTES; k++) begin
					rd_idx_out <= 5'(k);
					repeat (2) @(posedge sys_clk_in);
					// a slow master holds the index longer
					if (slow_in)
						repeat (3) @(posedge sys_clk_in);
					frame_out[k] = sect_byte_in;
				end
				done_out <= 1'b1;
				@(posedge sys_clk_in);
				done_out <= 1'b0;
				busy_out <= 1'b0;
			end
		end
	end
endmodule

// ### bench/test_dis_builder.sv
// self-checking bench for the interrupt section builder
`timescale 1ns/1ps
module test_dis_builder;
	import dis_pkg::*;
	logic        sys_clk_in, nrst_in, s_axi_awvalid, s_axi_wvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_rready, alarm_req_in;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, alarm_ready_out, sect_valid_out;
	logic        sect_done_in, mstart, mslow, mbusy;
	logic [1:0]  s_axi_bresp, s_axi_rresp, alarm_kind_in, rsp;
	logic [3:0]  s_axi_wstrb;
	logic [4:0]  sect_rd_idx_in;
	logic [5:0]  sect_len_out, nseq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, alarm_slot_in, sect_rd_byte_out;
	logic [7:0]  alarm_modtype_in, alarm_chlen_in, alarm_chcnt_in;
	logic [31:0] s_axi_wdata, s_axi_rdata, alarm_rec0_in, rdat;
	logic [63:0] alarm_chevt_in;
	dis_sect_t   mframe;
	int          err_count, n_tests;

	dis_builder dut (.*);
	dis_master_model master (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .start_in(mstart),
		.slow_in(mslow), .sect_valid_in(sect_valid_out),
		.sect_byte_in(sect_rd_byte_out), .rd_idx_out(sect_rd_idx_in),
		.done_out(sect_done_in), .busy_out(mbusy), .frame_out(mframe));

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		err_count++;
		test_done;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle count is assumed: only the watchdog ends this wait
		do begin
			@(posedge sys_clk_in);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rsp = s_axi_rresp;
		rdat = s_axi_rdata;
	endtask

	task automatic alarm(input logic [1:0] k, input logic [7:0] s,
		input logic [31:0] r0);
		@(posedge sys_clk_in);
		alarm_req_in <= 1'b1;
		alarm_kind_in <= k;
		alarm_slot_in <= s;
		alarm_rec0_in <= r0;
		@(posedge sys_clk_in);
		alarm_req_in <= 1'b0;
	endtask

	task automatic bump;
		nseq = (nseq == 6'h20) ? 6'h01 : nseq + 6'h01;
	endtask

	function automatic dis_sect_t exp_sect(input logic [1:0] k,
		input logic [7:0] s, input logic [31:0] r0);
		dis_sect_t e;
		e = '0;
		e[0] = 8'h14;
		e[1] = (k == KIND_PROC) ? 8'h82 : 8'h81;
		e[2] = s;
		e[3] = {nseq[4:0], 1'b0, k};
		e[7:4] = r0;
		if (k != KIND_PROC) begin
			e[5] &= 8'h3f;
			e[6] &= 8'h7f;
			e[7] &= 8'h40;
			e[8] = alarm_modtype_in;
			e[9] = alarm_chlen_in;
			e[10] = alarm_chcnt_in;
			for (int g = 0; g < 8; g++)
				if (g < alarm_chcnt_in)
					e[12+g] = alarm_chevt_in[8*g+:8];
		end
		return e;
	endfunction

	task automatic sect(input logic [1:0] k, input logic [7:0] s,
		input logic [31:0] r0);
		dis_sect_t e;
		alarm(k, s, r0);
		// the module fields may have been set just before the call
		e = exp_sect(k, s, r0);
		@(posedge sys_clk_in);
		chk(sect_valid_out, 1'b1);
		chk(sect_len_out, 6'h14);
		for (int w = 0; w < 5; w++) begin
			rd(ADDR_SECT0 + 8'(4 * w));
			chk(rdat, e[4*w+:4]);
		end
		mstart <= 1'b1;
		@(posedge sys_clk_in);
		mstart <= 1'b0;
		// one more edge so the model's busy flag is seen before polling
		@(posedge sys_clk_in);
		while (mbusy)
			@(posedge sys_clk_in);
		for (int b = 0; b < 20; b++)
			chk(mframe[b], e[b]);
		chk(sect_valid_out, 1'b0);
		bump;
	endtask

	task automatic refuse(input logic [1:0] k, input logic [7:0] s);
		alarm(k, s, 32'h0);
		@(posedge sys_clk_in);
		chk(sect_valid_out, 1'b0);
	endtask

	initial begin
		nrst_in <= 1'b0;
		s_axi_awaddr <= 8'h00;
		s_axi_awvalid <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_araddr <= 8'h00;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		alarm_req_in <= 1'b0;
		alarm_kind_in <= 2'h0;
		alarm_slot_in <= 8'h01;
		alarm_rec0_in <= 32'h0;
		alarm_modtype_in <= 8'h73;
		alarm_chlen_in <= 8'h05;
		alarm_chcnt_in <= 8'h03;
		alarm_chevt_in <= 64'h8877665544332211;
		mstart <= 1'b0;
		mslow <= 1'b0;
		nseq = 6'h01;
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		rd(ADDR_CTRL);
		chk(rdat[0], 1'b1);
		rd(ADDR_STATUS);
		chk(rdat & 32'h00010003, 32'h00010000);
		rd(8'h40);
		chk(rsp, 2'h2);
		wr(ADDR_STATUS, 32'hffffffff);
		chk(rsp, 2'h0);
		wr(8'h40, 32'hffffffff);
		chk(rsp, 2'h2);
		// a write with byte lane 0 off must leave the enable alone
		s_axi_wstrb <= 4'h0;
		wr(ADDR_CTRL, 32'h0);
		s_axi_wstrb <= 4'hf;
		chk(rsp, 2'h0);
		rd(ADDR_CTRL);
		chk(rdat[0], 1'b1);
		sect(KIND_PROC, 8'h01, 32'hffffffff);
		sect(KIND_DIAG_IN, 8'h20, 32'hffffffff);
		mslow <= 1'b1;
		alarm_chcnt_in <= 8'h08;
		sect(KIND_DIAG_OUT, 8'h05, 32'h12345678);
		mslow <= 1'b0;
		// from here on no channel group is reported
		alarm_chcnt_in <= 8'h00;
		refuse(KIND_RSVD, 8'h01);
		refuse(KIND_DIAG_IN, 8'h00);
		refuse(KIND_PROC, 8'h21);
		rd(ADDR_STATUS);
		chk(rdat[1], 1'b1);
		wr(ADDR_CTRL, 32'h5);
		rd(ADDR_STATUS);
		chk(rdat[1], 1'b0);
		wr(ADDR_CTRL, 32'h0);
		refuse(KIND_DIAG_IN, 8'h01);
		chk(alarm_ready_out, 1'b0);
		wr(ADDR_CTRL, 32'h1);
		for (int i = 0; i < 28; i++) begin
			alarm(KIND_PROC, 8'h01, 32'h0);
			rd(ADDR_STATUS);
			chk(rdat[13:8], nseq);
			chk(rdat[0], 1'b1);
			bump;
			wr(ADDR_CTRL, 32'h3);
		end
		sect(KIND_DIAG_IN, 8'h10, 32'h0);
		sect(KIND_PROC, 8'h02, 32'h00ff00ff);
		test_done;
	end
endmodule
